// ==== design/addc_pkg.sv ====
// Package: shared constants for the add-with-carry datapath and condition evaluator
package addc_pkg;
    // ----------------------------------------
    // Flag word layout
    // ----------------------------------------
    localparam logic [7:0] FLAG_WORD_INDEX = 8'hE7; // Register 231 holds the flags
    localparam int FLAG_C_POS = 7;
    localparam int FLAG_Z_POS = 6;
    localparam int FLAG_S_POS = 5;
    localparam int FLAG_V_POS = 4;
    localparam int FLAG_D_POS = 3;
    localparam int FLAG_H_POS = 2;
    localparam int FLAG_USER_POS = 1;
    localparam int FLAG_MSEL_POS = 0;
    localparam logic [7:0] FLAG_WORD_RESET = 8'h00;

    // ----------------------------------------
    // Condition encodings
    // ----------------------------------------
    localparam logic [3:0] CC_NEVER = 4'h0;
    localparam logic [3:0] CC_SIGNED_BELOW = 4'h1;
    localparam logic [3:0] CC_SIGNED_AT_MOST = 4'h2;
    localparam logic [3:0] CC_UNSIGNED_AT_MOST = 4'h3;
    localparam logic [3:0] CC_WRAP_SET = 4'h4;
    localparam logic [3:0] CC_SIGN_SET = 4'h5;
    localparam logic [3:0] CC_SAME_VALUE = 4'h6;
    localparam logic [3:0] CC_CARRY_SET = 4'h7;
    localparam int CC_INVERT_POS = 3;

    // ----------------------------------------
    // Operations and pointer modes
    // ----------------------------------------
    typedef enum logic [1:0] {OP_ADD_BYTE, OP_ADC_BYTE, OP_ADC_WORD, OP_NONE} op_t;
    typedef enum logic [1:0] {PTR_NONE, PTR_POST_INC, PTR_PRE_DEC} ptr_mode_t;

    // ----------------------------------------
    // Timing: cycles per word add-with-carry form
    // ----------------------------------------
    localparam logic [4:0] CYC_WORK_PAIRS = 5'd10;
    localparam logic [4:0] CYC_FULL_PAIRS = 5'd12;
    localparam logic [4:0] CYC_IMM_WORD = 5'd14;
    localparam logic [2:0] BYTES_WORK_PAIRS = 3'd2;
    localparam logic [2:0] BYTES_FULL_PAIRS = 3'd3;
    localparam logic [2:0] BYTES_IMM_WORD = 3'd4;
    typedef enum logic [1:0] {FORM_WORK_PAIRS, FORM_FULL_PAIRS, FORM_IMM_WORD, FORM_OTHER} form_t;
endpackage

// ==== design/cond_eval.sv ====
// Condition-code evaluator for conditional jumps
`timescale 1ns/100ps
module cond_eval
    import addc_pkg::*;
(
    input wire logic [3:0] cc_i, // Condition field
    input wire logic [7:0] flags_i, // Current flag word
    output logic pass_o // Condition passes
);
    // Lower half of the table; bit 3 inverts
    logic base;
    logic c_f, z_f, s_f, v_f;
    assign c_f = flags_i[FLAG_C_POS];
    assign z_f = flags_i[FLAG_Z_POS];
    assign s_f = flags_i[FLAG_S_POS];
    assign v_f = flags_i[FLAG_V_POS];

    // ----------------------------------------
    // Base decode
    // ----------------------------------------
    always_comb begin
        case (cc_i[2:0])
            CC_NEVER[2:0]: base = 1'b0; // Never; inverted gives always
            CC_SIGNED_BELOW[2:0]: base = s_f ^ v_f;
            CC_SIGNED_AT_MOST[2:0]: base = z_f | (s_f ^ v_f);
            CC_UNSIGNED_AT_MOST[2:0]: base = c_f | z_f;
            CC_WRAP_SET[2:0]: base = v_f;
            CC_SIGN_SET[2:0]: base = s_f;
            CC_SAME_VALUE[2:0]: base = z_f;
            CC_CARRY_SET[2:0]: base = c_f;
            default: base = 1'b0;
        endcase
    end

    // Upper encodings are complements
    assign pass_o = base ^ cc_i[CC_INVERT_POS];
endmodule // cond_eval

// ==== design/addc_alu.sv ====
// Combinational byte/word adder with flag generation
`timescale 1ns/100ps
module addc_alu
    import addc_pkg::*;
(
    input wire op_t op_i, // Operation
    input wire logic [15:0] dst_i, // Destination operand
    input wire logic [15:0] src_i, // Source operand
    input wire logic [7:0] flags_i, // Flags before the instruction
    output logic [15:0] res_o, // Sum
    output logic [7:0] flags_o // Flags after the instruction
);
    logic cin;
    logic [8:0] bsum;
    logic [4:0] nib;
    logic [16:0] wsum;

    // Carry-in only for the with-carry forms
    assign cin = (op_i == OP_ADD_BYTE) ? 1'b0 : flags_i[FLAG_C_POS];
    assign bsum = {1'b0, dst_i[7:0]} + {1'b0, src_i[7:0]} + {8'h00, cin};
    assign nib = {1'b0, dst_i[3:0]} + {1'b0, src_i[3:0]} + {4'h0, cin};
    assign wsum = {1'b0, dst_i} + {1'b0, src_i} + {16'h0000, cin};

    // ----------------------------------------
    // Result and flags
    // ----------------------------------------
    always_comb begin
        flags_o = flags_i;
        res_o = dst_i;
        case (op_i)
            OP_ADD_BYTE, OP_ADC_BYTE: begin
                res_o = {dst_i[15:8], bsum[7:0]};
                flags_o[FLAG_C_POS] = bsum[8];
                flags_o[FLAG_Z_POS] = (bsum[7:0] == 8'h00);
                flags_o[FLAG_S_POS] = bsum[7];
                flags_o[FLAG_V_POS] = (dst_i[7] == src_i[7]) && (bsum[7] != dst_i[7]);
                flags_o[FLAG_D_POS] = 1'b0;
                flags_o[FLAG_H_POS] = nib[4];
            end
            OP_ADC_WORD: begin // D and H left as they were (undefined)
                res_o = wsum[15:0];
                flags_o[FLAG_C_POS] = wsum[16];
                flags_o[FLAG_Z_POS] = (wsum[15:0] == 16'h0000);
                flags_o[FLAG_S_POS] = wsum[15];
                flags_o[FLAG_V_POS] = (dst_i[15] == src_i[15]) && (wsum[15] != dst_i[15]);
            end
            default: ;
        endcase
    end
endmodule // addc_alu

// ==== design/addc_core.sv ====
// Add-with-carry datapath: operand addressing, pointer side effects, flags, jumps
//
// Summary of operation
// - Code 0 never passes, 8 always
// - Code 7 carry set, F carry clear
// - Code 6 zero set, E zero clear
// - Code D sign clear, 5 sign set
// - Codes 9/1: sign xor overflow 0/1
// - Codes A/2: zero or (S xor V)
// - Code B: C,Z clear; 3: C or Z
// - Indices 0-15, 0-255; pairs even only
// - Relative target: next address plus signed byte
// - Short index signed byte; long unsigned word
// - Bit position 0 LSB to 7 MSB
// - Byte ADC: sum with carry, D cleared
// - Byte add: no carry, D cleared, H updated
// - Word ADC: C Z S V, D H undefined
// - Post-increment pair after access, +1/+2
// - Pre-decrement pair before access, -1/-2
// - Flags in register 231; bit0 memory select (code keeps the flag word in flags_q, apart from regs_q[231])
`timescale 1ns/100ps
module addc_core
    import addc_pkg::*;
#(
    parameter int REG_COUNT = 256 // Register file depth
) (
    input wire logic clk_i, // 250 MHz core clock
    input wire logic nrst_i, // Async reset, active low
    // Instruction request
    input wire logic start_i, // One-cycle start pulse
    input wire op_t op_i, // Operation
    input wire form_t form_i, // Timing form for word ops
    input wire logic dst_full_i, // Destination uses full 8-bit index
    input wire logic [7:0] dst_idx_i, // Destination register index
    input wire logic src_full_i, // Source uses full 8-bit index
    input wire logic [7:0] src_idx_i, // Source register index
    input wire logic src_imm_i, // Source is immediate
    input wire logic [15:0] imm_i, // Immediate value
    input wire ptr_mode_t ptr_mode_i, // Pointer side effect on source pair
    input wire logic [3:0] ptr_idx_i, // Working pair used as pointer
    input wire logic [15:0] mem_data_i, // Memory word at pointer (same clock)
    input wire logic [3:0] wbase_i, // Working register group (high nibble)
    // Jump / address helpers
    input wire logic [3:0] cc_i, // Condition field
    input wire logic [15:0] next_pc_i, // Address of following instruction
    input wire logic [7:0] disp_i, // Signed displacement
    input wire logic [15:0] index_base_i, // Pointer pair value for indexing
    input wire logic [15:0] long_off_i, // Unsigned long offset
    input wire logic use_long_off_i, // Select long offset
    input wire logic [7:0] bit_src_i, // Byte for bit selection
    input wire logic [2:0] bit_pos_i, // Bit position
    // Flag word direct write
    input wire logic flag_wr_i, // Write flag word
    input wire logic [7:0] flag_wdata_i, // Flag word data
    // Outputs
    output logic busy_o, // Instruction in progress
    output logic done_o, // One-cycle completion pulse
    output logic [15:0] result_o, // Last result
    output logic [7:0] flag_word_o, // Flag register 231
    output logic memory_space_select_o, // Program/data selector
    output logic cond_pass_o, // Condition passes now
    output logic [15:0] jump_target_o, // Relative jump target
    output logic jump_taken_o, // Jump taken (registered)
    output logic [15:0] index_addr_o, // Indexed effective address
    output logic bit_value_o, // Selected bit
    output logic [15:0] ptr_addr_o, // Effective pointer address
    output logic [2:0] instr_bytes_o // Byte length, by form, of last started instruction
);
    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Working index maps into the current group
    function automatic logic [7:0] reg_addr(input logic full, input logic [7:0] idx,
                                            input logic [3:0] base);
        reg_addr = full ? idx : {base, idx[3:0]};
    endfunction

    // Pairs always start on an even register
    function automatic logic [7:0] pair_hi(input logic [7:0] a);
        pair_hi = {a[7:1], 1'b0};
    endfunction

    // Sign-extend a byte to 16 bits
    function automatic logic [15:0] sext8(input logic [7:0] b);
        sext8 = {{8{b[7]}}, b};
    endfunction

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] regs_q [REG_COUNT]; // Register file, flag word excluded
    logic [7:0] flags_q; // Flag word

    typedef enum {ST_IDLE, ST_RUN, ST_DONE} state_t;
    state_t state_q;
    logic [4:0] cnt_q; // Cycles left
    logic [15:0] res_q;
    logic [7:0] nflags_q;
    logic [2:0] bytes_q;
    logic jump_q;

    // Latched request
    op_t op_q;
    logic [7:0] dadr_q; // Destination address (pair high byte)
    logic [15:0] src_q; // Source value
    ptr_mode_t pm_q;
    logic [7:0] padr_q; // Pointer pair address

    // ----------------------------------------
    // Combinational decode
    // ----------------------------------------
    logic [7:0] dadr, sadr, padr;
    logic [15:0] dval, sval, ptr_val, ptr_eff;
    logic [15:0] alu_res;
    logic [7:0] alu_flags;
    logic word_op;
    logic [1:0] step;
    logic pass;
    logic [4:0] cyc;

    assign word_op = (op_i == OP_ADC_WORD);
    assign step = word_op ? 2'd2 : 2'd1;
    assign dadr = word_op ? pair_hi(reg_addr(dst_full_i, dst_idx_i, wbase_i))
                          : reg_addr(dst_full_i, dst_idx_i, wbase_i);
    assign sadr = word_op ? pair_hi(reg_addr(src_full_i, src_idx_i, wbase_i))
                          : reg_addr(src_full_i, src_idx_i, wbase_i);
    assign padr = pair_hi({wbase_i, ptr_idx_i});
    assign ptr_val = {regs_q[padr], regs_q[padr + 8'd1]};
    // Pre-decrement uses the lowered pointer for the access
    assign ptr_eff = (ptr_mode_i == PTR_PRE_DEC) ? ptr_val - {14'h0000, step} : ptr_val;
    assign ptr_addr_o = ptr_eff;

    // Source selection: immediate, memory via pointer, or register
    always_comb begin
        if (src_imm_i) begin
            sval = imm_i;
        end else if (ptr_mode_i != PTR_NONE) begin
            sval = word_op ? mem_data_i : {8'h00, mem_data_i[7:0]};
        end else if (word_op) begin
            sval = {regs_q[sadr], regs_q[sadr + 8'd1]};
        end else begin
            sval = {8'h00, regs_q[sadr]};
        end
    end

    // Destination read for the latched instruction
    assign dval = (op_q == OP_ADC_WORD) ? {regs_q[dadr_q], regs_q[dadr_q + 8'd1]}
                                        : {8'h00, regs_q[dadr_q]};

    addc_alu u_alu (
        .op_i(op_q),
        .dst_i(dval),
        .src_i(src_q),
        .flags_i(flags_q),
        .res_o(alu_res),
        .flags_o(alu_flags)
    );

    cond_eval u_cond (
        .cc_i(cc_i),
        .flags_i(flags_q),
        .pass_o(pass)
    );

    assign cond_pass_o = pass;
    // Relative target from the following address
    assign jump_target_o = next_pc_i + sext8(disp_i);
    // Short offset signed, long unsigned
    assign index_addr_o = index_base_i + (use_long_off_i ? long_off_i : sext8(disp_i));
    // Bit 0 is the LSB
    assign bit_value_o = bit_src_i[bit_pos_i];

    // Cycle count per form
    always_comb begin
        case (form_i)
            FORM_WORK_PAIRS: cyc = CYC_WORK_PAIRS;
            FORM_FULL_PAIRS: cyc = CYC_FULL_PAIRS;
            FORM_IMM_WORD: cyc = CYC_IMM_WORD;
            default: cyc = CYC_WORK_PAIRS;
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Completes after the documented cycle count from start
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'd0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_i && op_i != OP_NONE) begin
                        state_q <= ST_RUN;
                        // Start cycle, cnt+1 run cycles and the done cycle add up to cyc;
                        // one count too many here would stretch every form by a cycle
                        cnt_q <= cyc - 5'd3; // Start and done cycles included
                    end
                end
                ST_RUN: begin
                    if (cnt_q == 5'd0) begin
                        state_q <= ST_DONE;
                    end else begin
                        cnt_q <= cnt_q - 5'd1;
                    end
                end
                ST_DONE: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Latch the request at start
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            op_q <= OP_NONE;
            dadr_q <= 8'h00;
            src_q <= 16'h0000;
            pm_q <= PTR_NONE;
            padr_q <= 8'h00;
            bytes_q <= 3'd0;
        end else if (state_q == ST_IDLE && start_i) begin
            op_q <= op_i;
            dadr_q <= dadr;
            src_q <= sval;
            pm_q <= ptr_mode_i;
            padr_q <= padr;
            case (form_i)
                FORM_WORK_PAIRS: bytes_q <= BYTES_WORK_PAIRS;
                FORM_FULL_PAIRS: bytes_q <= BYTES_FULL_PAIRS;
                FORM_IMM_WORD: bytes_q <= BYTES_IMM_WORD;
                default: bytes_q <= BYTES_WORK_PAIRS;
            endcase
        end
    end

    // Register file: result at done, pointer update as documented
    // Cleared at reset so no sum or pointer ever starts from unknown bytes;
    // costs a reset tree on every byte of the file
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else begin
            if (state_q == ST_IDLE && start_i && ptr_mode_i == PTR_PRE_DEC) begin
                {regs_q[padr], regs_q[padr + 8'd1]} <= ptr_eff; // Before access
            end
            if (state_q == ST_DONE) begin
                if (op_q == OP_ADC_WORD) begin
                    {regs_q[dadr_q], regs_q[dadr_q + 8'd1]} <= res_q;
                end else begin
                    regs_q[dadr_q] <= res_q[7:0];
                end
                if (pm_q == PTR_POST_INC) begin // After the operation
                    {regs_q[padr_q], regs_q[padr_q + 8'd1]} <=
                        {regs_q[padr_q], regs_q[padr_q + 8'd1]}
                        + ((op_q == OP_ADC_WORD) ? 16'h0002 : 16'h0001);
                end
            end
        end
    end

    // Compute result one cycle before commit
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            res_q <= 16'h0000;
            nflags_q <= FLAG_WORD_RESET;
        end else if (state_q == ST_RUN) begin
            res_q <= alu_res;
            nflags_q <= alu_flags; // Uses carry held before the instruction
        end
    end

    // Flag word: written together with the destination
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flags_q <= FLAG_WORD_RESET;
        end else if (state_q == ST_DONE) begin
            flags_q <= {nflags_q[7:2], flags_q[FLAG_USER_POS], flags_q[FLAG_MSEL_POS]};
        end else if (flag_wr_i) begin
            flags_q <= flag_wdata_i;
        end
    end

    // Jump decision registered for the branch unit
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            jump_q <= 1'b0;
        end else begin
            jump_q <= pass;
        end
    end

    assign busy_o = (state_q != ST_IDLE);
    assign done_o = (state_q == ST_DONE);
    assign result_o = res_q;
    assign flag_word_o = flags_q;
    assign memory_space_select_o = flags_q[FLAG_MSEL_POS];
    assign jump_taken_o = jump_q;
    assign instr_bytes_o = bytes_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Timing checks count from the sampled start cycle, which is cycle 0
    never_cc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'h0) |-> !cond_pass_o) else $error("code 0 passed");
    always_cc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'h8) |-> cond_pass_o) else $error("code 8 failed");
    carry_cc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'h7) |-> (cond_pass_o == flags_q[FLAG_C_POS])) else $error("code 7 wrong");
    zero_cc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'hE) |-> (cond_pass_o == !flags_q[FLAG_Z_POS])) else $error("code E wrong");
    sign_cc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'hD) |-> (cond_pass_o == !flags_q[FLAG_S_POS])) else $error("code D wrong");
    wrap_cc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'h4) |-> (cond_pass_o == flags_q[FLAG_V_POS])) else $error("code 4 wrong");
    signed_ge_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'h9) |-> (cond_pass_o == (flags_q[5] == flags_q[4]))) else $error("code 9");
    signed_le_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'h2) |-> (cond_pass_o == (flags_q[6] | (flags_q[5] ^ flags_q[4]))))
        else $error("code 2 wrong");
    unsigned_gt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cc_i == 4'hB) |-> (cond_pass_o == !(flags_q[7] | flags_q[6]))) else $error("code B");
    byte_dclear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_q == ST_DONE && op_q != OP_ADC_WORD) |=> !flags_q[FLAG_D_POS])
        else $error("D not cleared");
    word_timing_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_q == ST_IDLE && start_i && op_i == OP_ADC_WORD && form_i == FORM_WORK_PAIRS)
        |-> ##9 done_o) else $error("word pair timing wrong");
    imm_timing_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_q == ST_IDLE && start_i && op_i == OP_ADC_WORD && form_i == FORM_IMM_WORD)
        |-> !done_o [*8] ##1 !done_o [*5] ##1 done_o) else $error("immediate timing wrong");
    target_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        jump_target_o == next_pc_i + {{8{disp_i[7]}}, disp_i}) else $error("target wrong");
endmodule // addc_core

// ==== sim/addc_core_tb_top.sv ====
// Self-checking testbench for the add-with-carry datapath and condition evaluator
`timescale 1ns/100ps
module addc_core_tb_top;
    import addc_pkg::*;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_i = 1'b0; // 250 MHz core clock
    logic nrst_i = 1'b0; // Held low for the first cycles
    logic start_i = 1'b0, dst_full_i = 1'b0, src_full_i = 1'b0, src_imm_i = 1'b0;
    logic use_long_off_i = 1'b0, flag_wr_i = 1'b0;
    op_t op_i = OP_NONE;
    form_t form_i = FORM_OTHER;
    ptr_mode_t ptr_mode_i = PTR_NONE;
    logic [7:0] dst_idx_i = 8'h00, src_idx_i = 8'h00, disp_i = 8'h00;
    logic [7:0] bit_src_i = 8'h00, flag_wdata_i = 8'h00;
    logic [3:0] ptr_idx_i = 4'h0, wbase_i = 4'h0, cc_i = 4'h0;
    logic [2:0] bit_pos_i = 3'h0;
    logic [15:0] imm_i = 16'h0000, mem_data_i = 16'h0000, next_pc_i = 16'h0000;
    logic [15:0] index_base_i = 16'h0000, long_off_i = 16'h0000;
    logic busy_o, done_o, memory_space_select_o, cond_pass_o, jump_taken_o, bit_value_o;
    logic [15:0] result_o, jump_target_o, index_addr_o, ptr_addr_o;
    logic [7:0] flag_word_o;
    logic [2:0] instr_bytes_o;
    int fail_count = 0; // Mismatches seen
    int check_count = 0; // Comparisons made
    int n; // Cycle counter inside an instruction
    // Condition rows: code, flags C Z S V, expected pass
    logic [11:0] rows [32] = '{12'h0F0, 12'h801, 12'h781, 12'h700, 12'hF80, 12'hF01,
        12'h641, 12'h600, 12'hE40, 12'hE01, 12'hD20, 12'hD01, 12'h521, 12'h500,
        12'h411, 12'h400, 12'hC10, 12'hC01, 12'h931, 12'h920, 12'h111, 12'h130,
        12'hA31, 12'hA70, 12'h271, 12'h200, 12'hB01, 12'hB40, 12'hB80, 12'h341,
        12'h300, 12'h381};
    // Word forms first, then one byte add on the default form
    logic [4:0] cyc [4] = '{5'd10, 5'd12, 5'd14, 5'd10};
    logic [2:0] byt [4] = '{3'd2, 3'd3, 3'd4, 3'd2};
    // Arithmetic rows: destination, immediate, expected sum, expected flag word
    logic [15:0] sums [3][4] = '{'{16'h00A0, 16'h8001, 16'h8002, 16'h0020},
        '{16'h00A1, 16'h00FF, 16'h0001, 16'h0084},
        '{16'h00A1, 16'h007F, 16'h0081, 16'h0034}};

    addc_core i_addc_core (.clk_i(clk_i), .nrst_i(nrst_i), .start_i(start_i), .op_i(op_i),
        .form_i(form_i), .dst_full_i(dst_full_i), .dst_idx_i(dst_idx_i),
        .src_full_i(src_full_i), .src_idx_i(src_idx_i), .src_imm_i(src_imm_i),
        .imm_i(imm_i), .ptr_mode_i(ptr_mode_i), .ptr_idx_i(ptr_idx_i),
        .mem_data_i(mem_data_i), .wbase_i(wbase_i), .cc_i(cc_i), .next_pc_i(next_pc_i),
        .disp_i(disp_i), .index_base_i(index_base_i), .long_off_i(long_off_i),
        .use_long_off_i(use_long_off_i), .bit_src_i(bit_src_i), .bit_pos_i(bit_pos_i),
        .flag_wr_i(flag_wr_i), .flag_wdata_i(flag_wdata_i), .busy_o(busy_o),
        .done_o(done_o), .result_o(result_o), .flag_word_o(flag_word_o),
        .memory_space_select_o(memory_space_select_o), .cond_pass_o(cond_pass_o),
        .jump_target_o(jump_target_o), .jump_taken_o(jump_taken_o),
        .index_addr_o(index_addr_o), .bit_value_o(bit_value_o), .ptr_addr_o(ptr_addr_o),
        .instr_bytes_o(instr_bytes_o));

    // Free-running clock, half period 2 ns
    always #2 clk_i = ~clk_i;

    // ----------------------------------------
    // Shared comparison and closing tasks
    // ----------------------------------------
    // Case inequality so an unknown never passes as a match
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(negedge clk_i);
        check("reset busy", busy_o, 1'b0);
        check("reset flags", flag_word_o, 8'h00);
        check("reset result", result_o, 16'h0000);
        nrst_i = 1'b1;
        $display("test reset finished");
        // Condition table through direct flag writes; jump follows one cycle later
        foreach (rows[i]) begin
            flag_wr_i = 1'b1;
            flag_wdata_i = {rows[i][7:4], 4'h0};
            cc_i = rows[i][11:8];
            @(negedge clk_i);
            flag_wr_i = 1'b0;
            check("pass", cond_pass_o, rows[i][0]);
            @(negedge clk_i);
            check("jump", jump_taken_o, rows[i][0]);
        end
        $display("test condition rows finished");
        // Flag word bit 0 is the memory space selector, bit 1 is free
        flag_wr_i = 1'b1;
        flag_wdata_i = 8'h03;
        @(negedge clk_i);
        check("flag word", flag_word_o, 8'h03);
        check("msel", memory_space_select_o, 1'b1);
        flag_wdata_i = 8'h02;
        @(negedge clk_i);
        flag_wr_i = 1'b0;
        check("msel", memory_space_select_o, 1'b0);
        // Relative target at both signed limits; short index offset at -128, long index offset at FFFF
        next_pc_i = 16'h1000;
        disp_i = 8'h80;
        index_base_i = 16'h8000;
        long_off_i = 16'hFFFF;
        @(negedge clk_i) check("target", jump_target_o, 16'h0F80);
        check("short index", index_addr_o, 16'h7F80);
        disp_i = 8'h7F;
        use_long_off_i = 1'b1;
        @(negedge clk_i) check("target", jump_target_o, 16'h107F);
        check("long index", index_addr_o, 16'h7FFF);
        bit_src_i = 8'hA5;
        for (int p = 0; p < 8; p++) begin
            bit_pos_i = 3'(p);
            @(negedge clk_i) check("bit", bit_value_o, 16'((8'hA5 >> p) & 8'h01));
        end
        $display("test address helpers finished");
        // Back-to-back instructions, each with a start refused while busy
        @(negedge clk_i);
        for (int f = 0; f < 4; f++) begin
            form_i = form_t'(f);
            op_i = (f == 3) ? OP_ADD_BYTE : OP_ADC_WORD;
            ptr_mode_i = (f == 3) ? PTR_POST_INC : PTR_NONE;
            dst_full_i = (f == 1);
            src_full_i = (f == 1);
            src_imm_i = (f == 2);
            dst_idx_i = 8'(16 * f + 2);
            src_idx_i = 8'(16 * f + 6);
            imm_i = 16'h8001;
            wbase_i = 4'(f + 1);
            ptr_idx_i = 4'h4;
            start_i = 1'b1;
            @(negedge clk_i);
            n = 0;
            while (done_o !== 1'b1 && n < 40) begin
                start_i = (n == 2);
                if (n == 1) check("busy", busy_o, 1'b1);
                @(negedge clk_i);
                n++;
            end
            start_i = 1'b0;
            if (n >= 40) begin
                fail_count++;
                final_report();
            end
            check("done cycle", 16'(n), 16'(cyc[f] - 5'd2));
            @(negedge clk_i);
            check("idle", busy_o, 1'b0);
            check("bytes", instr_bytes_o, byt[f]);
        end
        // Pair 0x44 was post-incremented to 1; pre-decrement shows it lowered
        ptr_mode_i = PTR_PRE_DEC;
        @(negedge clk_i) check("pointer", ptr_addr_o, 16'h0000);
        $display("test instruction timing finished");
        // Arithmetic on cleared registers; each row chains on the last sum, the with-carry rows also on the carry
        flag_wr_i = 1'b1;
        flag_wdata_i = 8'h80;
        @(negedge clk_i);
        flag_wr_i = 1'b0;
        foreach (sums[k]) begin
            op_i = op_t'(2'((k + 2) % 3));
            form_i = FORM_IMM_WORD;
            ptr_mode_i = PTR_NONE;
            dst_full_i = 1'b1;
            dst_idx_i = sums[k][0][7:0];
            src_imm_i = 1'b1;
            imm_i = sums[k][1];
            start_i = 1'b1;
            n = 0;
            do begin
                @(negedge clk_i);
                start_i = 1'b0;
                n++;
            end while (done_o !== 1'b1 && n < 40);
            if (n >= 40) begin
                fail_count++;
                final_report();
            end
            @(negedge clk_i);
            check("sum", result_o, sums[k][2]);
            check("flags", flag_word_o, sums[k][3]);
        end
        $display("test arithmetic finished");
        // Reset in mid-instruction returns to idle at once
        op_i = OP_ADC_BYTE;
        start_i = 1'b1;
        repeat (3) @(negedge clk_i);
        start_i = 1'b0;
        nrst_i = 1'b0;
        #1 check("mid reset busy", busy_o, 1'b0);
        check("mid reset flags", flag_word_o, 8'h00);
        @(negedge clk_i);
        nrst_i = 1'b1;
        $display("test mid-run reset finished");
        final_report();
    end
endmodule // addc_core_tb_top
